//--- bench/pin_board_model.sv
/*
 * Board seen by the two port pins: resolves each pin level from the
 * port driver, an external source and the internal pull-up.
 * Assumes the bench sets the external source; undriven pins float.
 */
`timescale 1ns/1ps
module pin_board_model #(
    parameter int WIDTH = 2
) (
    // Clock
    input  wire logic             ref_clk,
    // Port side
    input  wire logic [WIDTH-1:0] pinOut,
    input  wire logic [WIDTH-1:0] pinOe,
    input  wire logic [WIDTH-1:0] pullupOn,
    // External source
    input  wire logic [WIDTH-1:0] boardEn,
    input  wire logic [WIDTH-1:0] boardVal,
    // Resolved level back to the port
    output logic      [WIDTH-1:0] pinIn
);
    logic [WIDTH-1:0] lastLevel = '0;

    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Driver first, then board, then pull-up; a floating pin flips
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pinOe[i])
                pinIn[i] = pinOut[i];
            else if (boardEn[i])
                pinIn[i] = boardVal[i];
            else if (pullupOn[i])
                pinIn[i] = 1'b1;
            else
                pinIn[i] = ~lastLevel[i];
        end
    end

    // Remember last level so a floating pin never settles
    always_ff @(posedge ref_clk) begin
        lastLevel <= pinIn;
    end
endmodule

//--- bench/tb_top.sv
/*
 * Self-checking bench for the two-pin port: APB tasks and scripted tests.
 * Assumes the design answers each transfer after a bounded wait.
 */
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] A_DATA = {gpio_port_pkg::DATA_LATCH_INDEX, 2'b00};
    localparam logic [7:0] A_PULL = {gpio_port_pkg::PULLUP_INDEX, 2'b00};
    localparam logic [7:0] A_DIR  = {gpio_port_pkg::DIRECTION_INDEX, 2'b00};

    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pinIn;
    logic [1:0]  pinOut;
    logic [1:0]  pinOe;
    logic [1:0]  pullupOn;
    logic [1:0]  boardEn = 2'h0;
    logic [1:0]  boardVal = 2'h0;
    logic        lowFreqReceiverEn = 1'b0;
    logic        stopPoweredOff = 1'b0;
    logic        stopStateRetained = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          n_checks = 0;

    two_bit_gpio_port_b #(.WIDTH(2)) two_bit_gpio_port_b_inst (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
        .lowFreqReceiverEn(lowFreqReceiverEn),
        .stopPoweredOff(stopPoweredOff),
        .stopStateRetained(stopStateRetained)
    );

    pin_board_model #(.WIDTH(2)) pin_board_model_inst (
        .ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .boardEn(boardEn), .boardVal(boardVal),
        .pinIn(pinIn)
    );

    // ------------------------------------------------------------
    // Clock, checks and closing
    // ------------------------------------------------------------
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            check(32'h0000_0001, 32'h0000_0000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Let pin outputs settle, then compare them
    task automatic pins_chk(input logic [1:0] oe, input logic [1:0] o,
                            input logic [1:0] pu);
        repeat (3) @(posedge ref_clk);
        check({26'h0, pinOe, pinOut, pullupOn}, {26'h0, oe, o, pu});
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values
        pins_chk(2'h0, 2'h0, 2'h0);
        rd_chk(A_DIR, 32'h0000_0000);
        rd_chk(A_PULL, 32'h0000_0000);
        end_test("reset");
        // Outputs, reserved bits, pull-up ignored on outputs
        apb(1'b1, A_DIR, 32'h0000_00FF);
        apb(1'b1, A_PULL, 32'h0000_00FF);
        apb(1'b1, A_DATA, 32'h0000_00FE);
        rd_chk(A_DIR, 32'h0000_0003);
        rd_chk(A_PULL, 32'h0000_0003);
        rd_chk(A_DATA, 32'h0000_0002);
        pins_chk(2'h3, 2'h2, 2'h0);
        end_test("outputs");
        // Inputs: board level, then pull-ups alone
        boardEn <= 2'h3;
        boardVal <= 2'h1;
        apb(1'b1, A_DIR, 32'h0000_0000);
        pins_chk(2'h0, 2'h0, 2'h3);
        rd_chk(A_DATA, 32'h0000_0001);
        boardEn <= 2'h0;
        repeat (3) @(posedge ref_clk);
        rd_chk(A_DATA, 32'h0000_0003);
        end_test("inputs");
        // Mixed directions; latch written while pin is input
        boardEn <= 2'h1;
        boardVal <= 2'h0;
        apb(1'b1, A_DATA, 32'h0000_0000);
        apb(1'b1, A_DIR, 32'h0000_0002);
        rd_chk(A_DATA, 32'h0000_0000);
        apb(1'b1, A_DATA, 32'h0000_0003);
        rd_chk(A_DATA, 32'h0000_0002);
        pins_chk(2'h2, 2'h2, 2'h1);
        end_test("mixed");
        // Receiver owns the pins
        lowFreqReceiverEn <= 1'b1;
        pins_chk(2'h0, 2'h0, 2'h0);
        rd_chk(A_DIR, 32'h0000_0002);
        lowFreqReceiverEn <= 1'b0;
        pins_chk(2'h2, 2'h2, 2'h1);
        end_test("receiver");
        // Retained stop keeps state and drops writes
        stopStateRetained <= 1'b1;
        lowFreqReceiverEn <= 1'b1;
        apb(1'b1, A_DIR, 32'h0000_0001);
        rd_chk(A_DIR, 32'h0000_0002);
        pins_chk(2'h2, 2'h2, 2'h1);
        stopStateRetained <= 1'b0;
        lowFreqReceiverEn <= 1'b0;
        end_test("retained");
        // Powered-off stop returns registers and pins to reset
        stopPoweredOff <= 1'b1;
        repeat (2) @(posedge ref_clk);
        stopPoweredOff <= 1'b0;
        pins_chk(2'h0, 2'h0, 2'h0);
        rd_chk(A_DIR, 32'h0000_0000);
        rd_chk(A_PULL, 32'h0000_0000);
        // Latch only readable through outputs
        apb(1'b1, A_DIR, 32'h0000_0003);
        rd_chk(A_DATA, 32'h0000_0000);
        apb(1'b1, A_DIR, 32'h0000_0000);
        end_test("powered_off");
        // Unmapped and unaligned addresses
        apb(1'b1, 8'h18, 32'h0000_0003);
        check({31'h0, err}, 32'h0000_0001);
        rd_chk(8'h11, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        rd_chk(A_DIR, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0000);
        end_test("unmapped");
        // Mid-run reset clears latch, direction and pull-ups
        apb(1'b1, A_DIR, 32'h0000_0003);
        apb(1'b1, A_PULL, 32'h0000_0003);
        apb(1'b1, A_DATA, 32'h0000_0003);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        pins_chk(2'h0, 2'h0, 2'h0);
        rd_chk(A_PULL, 32'h0000_0000);
        rd_chk(A_DIR, 32'h0000_0000);
        apb(1'b1, A_DIR, 32'h0000_0003);
        rd_chk(A_DATA, 32'h0000_0000);
        end_test("mid_reset");
        stop_test();
    end
endmodule

//--- core/gpio_port_pkg.sv
/*
 * Constants, register map and types for the two-pin general purpose port.
 * Assumes one 10 MHz clock, a synchronous active-high reset and APB access.
 */
package gpio_port_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0] DATA_LATCH_INDEX = 6'h04;
    localparam logic [5:0] PULLUP_INDEX     = 6'h05;
    localparam logic [5:0] DIRECTION_INDEX  = 6'h07;
    localparam int         ADDR_WIDTH       = 8;
    localparam int         INDEX_LSB        = 2;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int         PIN_COUNT        = 2;
    localparam int         REG_WIDTH        = 8;
    localparam logic [7:0] LATCH_RESET      = 8'h00;
    localparam logic [7:0] PULLUP_RESET     = 8'h00;
    localparam logic [7:0] DIRECTION_RESET  = 8'h00;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_DATA,
        SEL_PULLUP,
        SEL_DIRECTION
    } reg_select_type;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_type;

endpackage

//--- core/pad_ctrl_if.sv
/*
 * Carrier between the port core and its pad control cell.
 * Assumes both ends share the port width.
 */
`timescale 1ns/1ps
interface pad_ctrl_if #(
    parameter int WIDTH = 2
);
    // Configuration from the core
    logic [WIDTH-1:0] dirBits;
    logic [WIDTH-1:0] latchBits;
    logic [WIDTH-1:0] pullBits;
    logic             rxBlock;
    // Pad controls back to the core
    logic [WIDTH-1:0] driveEn;
    logic [WIDTH-1:0] driveVal;
    logic [WIDTH-1:0] pullOn;

    modport core (
        output dirBits, latchBits, pullBits, rxBlock,
        input  driveEn, driveVal, pullOn
    );
    modport pad (
        input  dirBits, latchBits, pullBits, rxBlock,
        output driveEn, driveVal, pullOn
    );
endinterface

//--- core/pin_pad_cell.sv
/*
 * Per-pin driver, value and pull-up decisions for the port pins.
 * Assumes the core registers every result before it reaches a pin.
 */
`timescale 1ns/1ps
module pin_pad_cell #(
    parameter int WIDTH = 2
) (
    // Pad control carrier
    pad_ctrl_if.pad pads
);

    // ----------------------------------------------------------------
    // One decision cell per pin
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            // Driver on only for outputs while receiver is off
            assign pads.driveEn[i]  = pads.dirBits[i] & ~pads.rxBlock;
            // Output value is the latch, parked low when undriven
            assign pads.driveVal[i] = pads.latchBits[i] & pads.dirBits[i]
                                      & ~pads.rxBlock;
            // Pull-up only on inputs, never while receiver owns pin
            assign pads.pullOn[i]   = pads.pullBits[i] & ~pads.dirBits[i]
                                      & ~pads.rxBlock;
        end
    endgenerate

endmodule

//--- core/two_bit_gpio_port_b.sv
/*
 * Two-pin general purpose port with data latch, direction and pull-up
 * registers behind an APB slave.
 * Assumes pin inputs already synchronous to ref_clk, the pad ring
 * resolving the pin from output, enable and pull-up, and the low
 * power controller giving the stop mode levels.
 */
`timescale 1ns/1ps
module two_bit_gpio_port_b #(
    parameter int WIDTH = gpio_port_pkg::PIN_COUNT
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Port pins
    input  wire logic [WIDTH-1:0]     pinIn,
    output logic      [WIDTH-1:0]     pinOut,
    output logic      [WIDTH-1:0]     pinOe,
    output logic      [WIDTH-1:0]     pullupOn,
    // Shared receiver and stop modes
    input  wire logic                 lowFreqReceiverEn,
    input  wire logic                 stopPoweredOff,
    input  wire logic                 stopStateRetained
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    generate
        if (WIDTH < 1 || WIDTH > gpio_port_pkg::REG_WIDTH) begin : g_bad
            $error("Port width must be 1 to 8");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0]            latch;
        logic [WIDTH-1:0]            dir;
        logic [WIDTH-1:0]            pull;
        logic [WIDTH-1:0]            sample;
        logic [WIDTH-1:0]            pinOut;
        logic [WIDTH-1:0]            pinOe;
        logic [WIDTH-1:0]            pullupOn;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        gpio_port_pkg::bus_state_type bus;
    } state_type;

    state_type st;
    state_type next_st;
    state_type resetState;

    gpio_port_pkg::reg_select_type sel;
    logic                          writeTaken;
    logic                          readTaken;

    pad_ctrl_if #(.WIDTH(WIDTH)) pads ();

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Word-aligned index to register select
    function automatic gpio_port_pkg::reg_select_type regSelect(
        input logic [7:0] addr
    );
        gpio_port_pkg::reg_select_type s;
        s = gpio_port_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[7:gpio_port_pkg::INDEX_LSB])
                gpio_port_pkg::DATA_LATCH_INDEX: s = gpio_port_pkg::SEL_DATA;
                gpio_port_pkg::PULLUP_INDEX:     s = gpio_port_pkg::SEL_PULLUP;
                gpio_port_pkg::DIRECTION_INDEX:
                    s = gpio_port_pkg::SEL_DIRECTION;
                default:                         s = gpio_port_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Decode and the edge on which a transfer completes
    assign sel        = regSelect(paddr);
    assign writeTaken = psel && penable && st.pready && pwrite;
    assign readTaken  = psel && penable && st.pready && !pwrite;

    // ----------------------------------------------------------------
    // Pad control cell
    // ----------------------------------------------------------------
    // Configuration out to the per-pin cell
    assign pads.dirBits   = st.dir;
    assign pads.latchBits = st.latch;
    assign pads.pullBits  = st.pull;
    assign pads.rxBlock   = lowFreqReceiverEn;

    pin_pad_cell #(
        .WIDTH (WIDTH)
    ) u_pads (
        .pads  (pads.pad)
    );

    // ----------------------------------------------------------------
    // Reset image
    // ----------------------------------------------------------------
    // Latch cleared, all inputs, pull-ups off, bus idle
    always_comb begin
        resetState          = '0;
        resetState.latch    = gpio_port_pkg::LATCH_RESET[WIDTH-1:0];
        resetState.dir      = gpio_port_pkg::DIRECTION_RESET[WIDTH-1:0];
        resetState.pull     = gpio_port_pkg::PULLUP_RESET[WIDTH-1:0];
        resetState.prdata   = gpio_port_pkg::WORD_ZERO;
        resetState.bus      = gpio_port_pkg::BUS_IDLE;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Bus answer, register writes, pin updates, stop and reset
    always_comb begin
        next_st        = st;
        next_st.sample = pinIn;
        case (st.bus)
            gpio_port_pkg::BUS_IDLE: begin
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
                if (psel && penable) begin
                    next_st.bus     = gpio_port_pkg::BUS_ANSWER;
                    next_st.pready  = 1'b1;
                    next_st.pslverr = (sel == gpio_port_pkg::SEL_NONE);
                    // Upper bits stay zero
                    next_st.prdata  = gpio_port_pkg::WORD_ZERO;
                    if (!pwrite) begin
                        case (sel)
                            gpio_port_pkg::SEL_DATA: begin
                                // Inputs show the pin, outputs the latch
                                next_st.prdata[WIDTH-1:0] =
                                    (st.dir & st.latch)
                                    | (~st.dir & st.sample);
                            end
                            gpio_port_pkg::SEL_PULLUP: begin
                                next_st.prdata[WIDTH-1:0] = st.pull;
                            end
                            gpio_port_pkg::SEL_DIRECTION: begin
                                next_st.prdata[WIDTH-1:0] = st.dir;
                            end
                            default: begin
                                next_st.prdata = gpio_port_pkg::WORD_ZERO;
                            end
                        endcase
                    end
                end
            end
            gpio_port_pkg::BUS_ANSWER: begin
                next_st.bus     = gpio_port_pkg::BUS_IDLE;
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
                // Writes land only in the low bits; rest is dropped
                if (writeTaken && !stopStateRetained) begin
                    case (sel)
                        gpio_port_pkg::SEL_DATA: begin
                            next_st.latch = pwdata[WIDTH-1:0];
                        end
                        gpio_port_pkg::SEL_PULLUP: begin
                            next_st.pull = pwdata[WIDTH-1:0];
                        end
                        gpio_port_pkg::SEL_DIRECTION: begin
                            next_st.dir = pwdata[WIDTH-1:0];
                        end
                        default: begin
                            next_st.latch = st.latch;
                        end
                    endcase
                end
            end
            default: begin
                next_st.bus = gpio_port_pkg::BUS_IDLE;
            end
        endcase
        // Pins follow the cell unless the retained stop freezes them
        if (!stopStateRetained) begin
            next_st.pinOe    = pads.driveEn;
            next_st.pinOut   = pads.driveVal;
            next_st.pullupOn = pads.pullOn;
        end
        // Register contents lost, pins back to the reset state
        if (stopPoweredOff) begin
            next_st.latch    = resetState.latch;
            next_st.dir      = resetState.dir;
            next_st.pull     = resetState.pull;
            next_st.pinOe    = '0;
            next_st.pinOut   = '0;
            next_st.pullupOn = '0;
        end
        if (rst) begin
            next_st = resetState;
        end
    end

    // Single state register
    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // All straight from the state register
    assign prdata   = st.prdata;
    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign pinOut   = st.pinOut;
    assign pinOe    = st.pinOe;
    assign pullupOn = st.pullupOn;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Read answer presented to the master
    sequence s_readDone;
        psel && penable && pready && !pwrite;
    endsequence

    // Normal pin update, not frozen nor reset
    sequence s_pinsLive;
        !stopStateRetained && !stopPoweredOff && !lowFreqReceiverEn;
    endsequence

    property p_rx_hiz;
        @(posedge ref_clk) disable iff (rst)
        lowFreqReceiverEn && !stopStateRetained
        |=> (pinOe == '0) && (pullupOn == '0);
    endproperty
    a_rx_hiz: assert property (p_rx_hiz)
        else $error("Pin driven while receiver enabled");

    property p_read_input;
        @(posedge ref_clk) disable iff (rst)
        s_readDone ##0 (sel == gpio_port_pkg::SEL_DATA)
        |-> (prdata[WIDTH-1:0] & ~$past(st.dir))
            == ($past(st.sample) & ~$past(st.dir));
    endproperty
    a_read_input: assert property (p_read_input)
        else $error("Input pin read wrong level");

    property p_read_output;
        @(posedge ref_clk) disable iff (rst)
        s_readDone ##0 (sel == gpio_port_pkg::SEL_DATA)
        |-> (prdata[WIDTH-1:0] & $past(st.dir))
            == ($past(st.latch) & $past(st.dir));
    endproperty
    a_read_output: assert property (p_read_output)
        else $error("Output pin read not the latch");

    property p_write_latch;
        @(posedge ref_clk) disable iff (rst)
        writeTaken && (sel == gpio_port_pkg::SEL_DATA)
        && !stopStateRetained && !stopPoweredOff
        |=> (st.latch == $past(pwdata[WIDTH-1:0])) and
            (##1 s_pinsLive |=>
                ((pinOut & pinOe) == ($past(st.latch) & pinOe)));
    endproperty
    a_write_latch: assert property (p_write_latch)
        else $error("Latch write or drive missing");

    property p_reset_state;
        @(posedge ref_clk) disable iff (1'b0)
        rst |=> (st.latch == '0) && (pinOe == '0) && (pullupOn == '0)
                && (st.dir == '0) && !pready;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Reset state wrong");

    property p_pullup;
        @(posedge ref_clk) disable iff (rst)
        s_pinsLive |=> pullupOn == ($past(st.pull) & ~$past(st.dir));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("Pull-up control wrong");

    property p_direction_drive;
        @(posedge ref_clk) disable iff (rst)
        s_pinsLive |=> pinOe == $past(st.dir);
    endproperty
    a_direction_drive: assert property (p_direction_drive)
        else $error("Driver enable not following direction");

    property p_read_direction;
        @(posedge ref_clk) disable iff (rst)
        s_readDone ##0 (sel == gpio_port_pkg::SEL_DIRECTION)
        |-> prdata[WIDTH-1:0] == $past(st.dir);
    endproperty
    a_read_direction: assert property (p_read_direction)
        else $error("Direction read wrong");

    property p_powered_off;
        @(posedge ref_clk) disable iff (rst)
        stopPoweredOff |=> (st.latch == '0) && (st.dir == '0)
                           && (st.pull == '0) && (pinOe == '0);
    endproperty
    a_powered_off: assert property (p_powered_off)
        else $error("Powered-off stop did not restore defaults");

    property p_retained;
        @(posedge ref_clk) disable iff (rst)
        stopStateRetained && !stopPoweredOff
        |=> $stable(st.dir) && $stable(st.latch) && $stable(st.pull)
            && $stable(pinOe) && $stable(pinOut) && $stable(pullupOn);
    endproperty
    a_retained: assert property (p_retained)
        else $error("Retained stop changed pin state");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (rst)
        s_readDone |-> prdata[31:WIDTH] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits read nonzero");

    property p_answer_timing;
        @(posedge ref_clk) disable iff (rst)
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_answer_timing: assert property (p_answer_timing)
        else $error("Bus answer not one wait state");

endmodule
